// *** logic/tsa_station_add.sv ***
// station-addition logic: ack-requested polls, join status replies, scan handling
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tsa_station_add (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // received frames
  input wire logic rx_valid_i,
  input tsa_pkg::tsa_kind_t rx_kind_i,
  input wire logic [7:0] rx_da_i,
  input wire logic [7:0] rx_sa_i,
  input wire logic [7:0] rx_tc_i,
  input wire logic [7:0] rx_ac_i,
  // token hand-off request from the access logic
  input wire logic tok_pass_i,
  // transmit frames
  output logic tx_valid_o,
  output tsa_pkg::tsa_kind_t tx_kind_o,
  output logic [7:0] tx_da_o,
  output logic [7:0] tx_tc_o,
  output logic [7:0] tx_ac_o,
  input wire logic tx_ready_i,
  // frame status write-back and state
  output logic fs_wr_o,
  output logic [9:0] fs_code_o,
  output logic na_changed_o,
  output logic scan_mode_o
);
  import tsa_pkg::*;

  tsa_state_t state_reg, state_next;
  logic [2:0] ctrl_reg;
  logic [7:0] own_reg;
  logic [7:0] na_reg;
  logic [7:0] ackwait_reg;
  logic [7:0] poll_da_reg;
  logic [9:0] result_reg;
  logic poll_pend_reg, tok_pend_reg, ack_pend_reg;
  logic [7:0] ack_da_reg;
  logic try_reg, scan_reg, nachg_reg;
  logic tx_valid_reg;
  tsa_kind_t tx_kind_reg;
  logic [7:0] tx_da_reg, tx_tc_reg, tx_ac_reg;
  logic fs_wr_reg;
  logic [9:0] fs_code_reg;
  logic [31:0] rdata_reg;
  logic [7:0] ack_ac;

  logic wr_ctrl, wr_own, wr_next, wr_stat, wr_ackwait, wr_poll;
  logic tx_done, ack_req_in, scan_in, poll_hit, tok_hit, tok_fail, advance;

  tsa_tmr_if tmr_if ();

  tsa_ack_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .tmr(tmr_if.timer)
  );

  tsa_ack_builder u_builder (
    .join_i(ctrl_reg[CTRL_JOIN_BIT]),
    .rxonly_i(ctrl_reg[CTRL_RXONLY_BIT]),
    .ring_join_request_i(ctrl_reg[CTRL_RING_JOIN_REQUEST_BIT]),
    .ac_o(ack_ac)
  );

  // decode and event terms
  assign wr_ctrl = reg_wr_i && reg_addr_i == REG_CTRL;
  assign wr_own = reg_wr_i && reg_addr_i == REG_OWN;
  assign wr_next = reg_wr_i && reg_addr_i == REG_NEXT;
  assign wr_stat = reg_wr_i && reg_addr_i == REG_STATUS;
  assign wr_ackwait = reg_wr_i && reg_addr_i == REG_ACKWAIT;
  assign wr_poll = reg_wr_i && reg_addr_i == REG_POLL;
  assign tx_done = tx_valid_reg && tx_ready_i;
  assign ack_req_in = rx_valid_i && rx_kind_i == KIND_DATA && rx_tc_i == TC_ACK_REQ &&
                      tsa_for_me(rx_da_i, own_reg, 1'b0);
  assign scan_in = rx_valid_i && rx_kind_i == KIND_SCAN &&
                   tsa_for_me(rx_da_i, own_reg, 1'b1);
  assign poll_hit = state_reg == ST_POLL_WAIT && rx_valid_i && rx_kind_i == KIND_ACK &&
                    rx_sa_i == poll_da_reg && tsa_for_me(rx_da_i, own_reg, 1'b0);
  assign tok_hit = state_reg == ST_TOK_WAIT && rx_valid_i && rx_sa_i == na_reg;
  assign tok_fail = state_reg == ST_TOK_WAIT && tmr_if.expired && !tok_hit;
  // outside scan the same address gets a second chance; in scan each only one
  assign advance = tok_fail && (scan_reg || try_reg);

  assign tmr_if.start = tx_done && (state_reg == ST_POLL_SEND || state_reg == ST_TOK_SEND);
  assign tmr_if.stop = poll_hit || tok_hit;
  assign tmr_if.limit = ackwait_reg;

  assign reg_rdata_o = rdata_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_kind_o = tx_kind_reg;
  assign tx_da_o = tx_da_reg;
  assign tx_tc_o = tx_tc_reg;
  assign tx_ac_o = tx_ac_reg;
  assign fs_wr_o = fs_wr_reg;
  assign fs_code_o = fs_code_reg;
  assign na_changed_o = nachg_reg;
  assign scan_mode_o = scan_reg;

  // control sequencer; replies come first so a poller is never starved
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ack_pend_reg) begin
          state_next = ST_ACK_SEND;
        end else if (tok_pend_reg) begin
          state_next = ST_TOK_SEND;
        end else if (poll_pend_reg) begin
          state_next = ST_POLL_SEND;
        end
      end
      ST_ACK_SEND: if (tx_done) state_next = ST_IDLE;
      ST_POLL_SEND: if (tx_done) state_next = ST_POLL_WAIT;
      ST_POLL_WAIT: if (poll_hit || tmr_if.expired) state_next = ST_IDLE;
      ST_TOK_SEND: if (tx_done) state_next = ST_TOK_WAIT;
      ST_TOK_WAIT: begin
        if (tok_hit) begin
          state_next = ST_IDLE;
        end else if (tmr_if.expired) begin
          state_next = ST_TOK_SEND;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // software control registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= CTRL_RST;
      own_reg <= OWN_RST;
      ackwait_reg <= ACKWAIT_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata_i[2:0];
      if (wr_own && tsa_valid_addr(reg_wdata_i[7:0])) own_reg <= reg_wdata_i[7:0];
      if (wr_ackwait) ackwait_reg <= reg_wdata_i[7:0];
    end
  end

  // pending work; a new token request in the cycle it is taken stays pending, a new poll or reply request is lost
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      poll_pend_reg <= 1'b0;
      poll_da_reg <= ADDR_MIN;
      tok_pend_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      ack_da_reg <= ADDR_MIN;
    end else begin
      if (wr_poll && !poll_pend_reg && state_reg != ST_POLL_SEND &&
          state_reg != ST_POLL_WAIT) begin
        poll_pend_reg <= 1'b1;
        poll_da_reg <= reg_wdata_i[7:0];
      end else if (state_reg == ST_IDLE && state_next == ST_POLL_SEND) begin
        poll_pend_reg <= 1'b0;
      end
      if (tok_pass_i) begin
        tok_pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && state_next == ST_TOK_SEND) begin
        tok_pend_reg <= 1'b0;
      end
      // one reply slot: a request arriving while another reply waits is lost
      if (ack_req_in && !ack_pend_reg) begin
        ack_pend_reg <= 1'b1;
        ack_da_reg <= rx_sa_i;
      end else if (state_reg == ST_IDLE && state_next == ST_ACK_SEND) begin
        ack_pend_reg <= 1'b0;
      end
    end
  end

  // next-station register and search state
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      na_reg <= NEXT_RST;
      scan_reg <= 1'b0;
      try_reg <= 1'b0;
    end else begin
      if (scan_in) begin
        na_reg <= tsa_step(own_reg);
        scan_reg <= 1'b1;
      end else if (advance) begin
        na_reg <= tsa_step(na_reg);
        scan_reg <= 1'b1;
      end else if (wr_next && tsa_valid_addr(reg_wdata_i[7:0])) begin
        na_reg <= reg_wdata_i[7:0];
      end
      // a scan arriving with the answer restarts the search, so it keeps scan mode
      if (tok_hit && !scan_in) scan_reg <= 1'b0;
      if (state_reg == ST_IDLE && state_next == ST_TOK_SEND) begin
        try_reg <= 1'b0;
      end else if (tok_fail) begin
        try_reg <= !(scan_reg || try_reg);
      end
    end
  end

  // sticky change notice; hardware set wins over software clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nachg_reg <= 1'b0;
    end else if (scan_in || advance) begin
      nachg_reg <= 1'b1;
    end else if (wr_stat && reg_wdata_i[STAT_NACHG_BIT]) begin
      nachg_reg <= 1'b0;
    end
  end

  // transmit frame, loaded on entry to a send state and held until taken
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_valid_reg <= 1'b0;
      tx_kind_reg <= KIND_DATA;
      tx_da_reg <= 8'h00;
      tx_tc_reg <= TC_NONE;
      tx_ac_reg <= 8'h00;
    end else if (tx_done) begin
      tx_valid_reg <= 1'b0;
    end else if (state_reg != state_next) begin
      case (state_next)
        ST_ACK_SEND: begin
          tx_valid_reg <= 1'b1;
          tx_kind_reg <= KIND_ACK;
          tx_da_reg <= ack_da_reg;
          tx_tc_reg <= TC_NONE;
          tx_ac_reg <= ack_ac;
        end
        ST_POLL_SEND: begin
          tx_valid_reg <= 1'b1;
          tx_kind_reg <= KIND_DATA;
          tx_da_reg <= poll_da_reg;
          tx_tc_reg <= TC_ACK_REQ;
          tx_ac_reg <= 8'h00;
        end
        ST_TOK_SEND: begin
          tx_valid_reg <= 1'b1;
          tx_kind_reg <= KIND_TOKEN;
          tx_da_reg <= advance ? tsa_step(na_reg) : na_reg;
          tx_tc_reg <= advance ? tsa_step(na_reg) : na_reg;
          tx_ac_reg <= 8'h00;
        end
        default: tx_valid_reg <= 1'b0;
      endcase
    end
  end

  // poll outcome written back once per attempt
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fs_wr_reg <= 1'b0;
      fs_code_reg <= 10'h000;
      result_reg <= 10'h000;
    end else begin
      fs_wr_reg <= 1'b0;
      if (poll_hit) begin
        fs_wr_reg <= 1'b1;
        fs_code_reg <= {OUT_ACKED, rx_ac_i};
        result_reg <= {OUT_ACKED, rx_ac_i};
      end else if (state_reg == ST_POLL_WAIT && tmr_if.expired) begin
        fs_wr_reg <= 1'b1;
        fs_code_reg <= {OUT_TIMEOUT, 8'h00};
        result_reg <= {OUT_TIMEOUT, 8'h00};
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= 32'h0000_0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          REG_CTRL: rdata_reg <= {29'h0000_0000, ctrl_reg};
          REG_OWN: rdata_reg <= {24'h00_0000, own_reg};
          REG_NEXT: rdata_reg <= {24'h00_0000, na_reg};
          REG_STATUS: rdata_reg <= {28'h000_0000, poll_pend_reg, scan_reg,
                                    state_reg != ST_IDLE, nachg_reg};
          REG_ACKWAIT: rdata_reg <= {24'h00_0000, ackwait_reg};
          REG_POLL: rdata_reg <= {24'h00_0000, poll_da_reg};
          REG_RESULT: rdata_reg <= {22'h00_0000, result_reg};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence poll_timed_out_s;
    state_reg == ST_POLL_WAIT && tmr_if.expired && !poll_hit;
  endsequence
  sequence reply_due_s;
    state_reg == ST_IDLE && ack_pend_reg;
  endsequence
  sequence scan_seen_s;
    scan_in;
  endsequence

  poll_ack_tc_a: assert property (
    state_reg == ST_POLL_SEND && tx_valid_o |-> tx_tc_o == TC_ACK_REQ &&
    tx_kind_o == KIND_DATA && tx_da_o == poll_da_reg)
    else $error("poll frame does not request an acknowledge");

  poll_abandon_a: assert property (
    poll_timed_out_s |=> state_reg == ST_IDLE && fs_wr_o && fs_code_o[9:8] == OUT_TIMEOUT)
    else $error("poll not abandoned after acknowledge wait");

  poll_status_a: assert property (
    poll_hit |=> fs_wr_o && fs_code_o == {OUT_ACKED, $past(rx_ac_i)} ##1 !fs_wr_o)
    else $error("poll outcome not written once");

  ack_reply_a: assert property (
    reply_due_s |=> tx_valid_o && tx_kind_o == KIND_ACK && tx_da_o == $past(ack_da_reg))
    else $error("acknowledge reply not sent to requester");

  join_flag_a: assert property (
    $rose(tx_valid_o) && tx_kind_o == KIND_ACK |->
    tx_ac_o[AC_JOIN_BIT] == $past(ctrl_reg[CTRL_JOIN_BIT]) &&
    tx_ac_o[AC_RXONLY_BIT] == $past(ctrl_reg[CTRL_RXONLY_BIT]) &&
    tx_ac_o[AC_RING_JOIN_REQUEST_BIT] == $past(ctrl_reg[CTRL_RING_JOIN_REQUEST_BIT]))
    else $error("reply status bits differ from control register");

  scan_load_a: assert property (
    scan_seen_s |=> na_reg == tsa_step($past(own_reg)) && scan_mode_o)
    else $error("scan command did not load own plus one");

  scan_notify_a: assert property (
    scan_seen_s |=> na_changed_o ##1
    (na_changed_o || $past(wr_stat && reg_wdata_i[STAT_NACHG_BIT])))
    else $error("next-station change not reported");

  tok_step_a: assert property (
    advance && !scan_in |=> na_reg == tsa_step($past(na_reg)) && state_reg == ST_TOK_SEND &&
    tx_da_o == na_reg)
    else $error("token timeout did not move to following address");

  na_range_a: assert property (
    na_reg >= ADDR_MIN && na_reg <= ADDR_MAX)
    else $error("next station outside usable range");

  tok_keep_a: assert property (
    tok_hit && !scan_in && !wr_next |=> $stable(na_reg) && !scan_mode_o &&
    state_reg == ST_IDLE)
    else $error("responding station not kept as next");
endmodule : tsa_station_add

// *** logic/tsa_pkg.sv ***
// shared constants, types and helper functions of the station-addition block
package tsa_pkg;
  // clock and acknowledge-wait timebase
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OWN = 8'h04;
  localparam logic [7:0] REG_NEXT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ACKWAIT = 8'h10;
  localparam logic [7:0] REG_POLL = 8'h14;
  localparam logic [7:0] REG_RESULT = 8'h18;

  // field positions
  localparam int unsigned CTRL_JOIN_BIT = 0;
  localparam int unsigned CTRL_RXONLY_BIT = 1;
  localparam int unsigned CTRL_RING_JOIN_REQUEST_BIT = 2;
  localparam int unsigned STAT_NACHG_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_SCAN_BIT = 2;
  localparam int unsigned STAT_POLLPEND_BIT = 3;
  localparam int unsigned AC_JOIN_BIT = 0;
  localparam int unsigned AC_RXONLY_BIT = 1;
  localparam int unsigned AC_RING_JOIN_REQUEST_BIT = 2;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] OWN_RST = 8'h01;
  localparam logic [7:0] NEXT_RST = 8'h02;
  localparam logic [7:0] ACKWAIT_RST = 8'h0A;

  // station numbers and token control values
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hFE;
  localparam logic [7:0] ADDR_GLOBAL = 8'hFF;
  localparam logic [7:0] TC_NONE = 8'h00;
  localparam logic [7:0] TC_ACK_REQ = 8'hFF;

  // poll outcome codes
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_ACKED = 2'h1;
  localparam logic [1:0] OUT_TIMEOUT = 2'h2;

  typedef enum logic [1:0] {KIND_DATA, KIND_TOKEN, KIND_SCAN, KIND_ACK} tsa_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACK_SEND, ST_POLL_SEND, ST_POLL_WAIT, ST_TOK_SEND, ST_TOK_WAIT
  } tsa_state_t;

  // circular step through usable station numbers
  function automatic logic [7:0] tsa_step(input logic [7:0] a);
    tsa_step = (a >= ADDR_MAX || a < ADDR_MIN) ? ADDR_MIN : a + 8'h01;
  endfunction : tsa_step

  function automatic logic tsa_valid_addr(input logic [7:0] a);
    tsa_valid_addr = (a >= ADDR_MIN) && (a <= ADDR_MAX);
  endfunction : tsa_valid_addr

  // frame destined to this station, optionally also by the global address
  function automatic logic tsa_for_me(input logic [7:0] da, input logic [7:0] own,
                                      input logic allow_global);
    tsa_for_me = (da == own) || (allow_global && da == ADDR_GLOBAL);
  endfunction : tsa_for_me
endpackage : tsa_pkg

// *** logic/tsa_tmr_if.sv ***
// carrier between the control fsm and the acknowledge wait timer
`timescale 1ns/1ps
interface tsa_tmr_if;
  logic start;
  logic stop;
  logic [7:0] limit;
  logic expired;
  modport timer (input start, input stop, input limit, output expired);
  modport user (output start, output stop, output limit, input expired);
endinterface : tsa_tmr_if

// *** logic/tsa_ack_timer.sv ***
// acknowledge wait timer counting in microsecond ticks
`timescale 1ns/1ps
module tsa_ack_timer (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // control
  tsa_tmr_if.timer tmr
);
  import tsa_pkg::*;

  logic [7:0] div_reg;
  logic [7:0] cnt_reg;
  logic run_reg;
  logic exp_reg;
  logic tick;

  // divider restarts with each start so the first tick is a full period away
  assign tick = run_reg && (div_reg == 8'(TICK_CYCLES - 1));
  assign tmr.expired = exp_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= 8'h00;
    end else if (tmr.start || tick || !run_reg) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 8'h00;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      exp_reg <= 1'b0;
      if (tmr.start) begin
        // a zero limit still waits one tick
        cnt_reg <= (tmr.limit == 8'h00) ? 8'h01 : tmr.limit;
        run_reg <= 1'b1;
      end else if (tmr.stop) begin
        run_reg <= 1'b0;
      end else if (tick) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          run_reg <= 1'b0;
          exp_reg <= 1'b1;
        end
      end
    end
  end
endmodule : tsa_ack_timer

// *** logic/tsa_ack_builder.sv ***
// builds the access-control byte carried by acknowledge replies
`timescale 1ns/1ps
module tsa_ack_builder (
  // control bits set by software
  input wire logic join_i,
  input wire logic rxonly_i,
  input wire logic ring_join_request_i,
  // reply byte
  output logic [7:0] ac_o
);
  import tsa_pkg::*;

  always_comb begin
    ac_o = 8'h00;
    ac_o[AC_JOIN_BIT] = join_i;
    ac_o[AC_RXONLY_BIT] = rxonly_i;
    ac_o[AC_RING_JOIN_REQUEST_BIT] = ring_join_request_i;
  end
endmodule : tsa_ack_builder

// *** testbench/tsa_net_model.sv ***
// other stations on the network side, answering polls and token passes
`timescale 1ns/1ps
module tsa_net_model
  import tsa_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // frames from the device
  input wire logic tx_valid_i,
  input tsa_pkg::tsa_kind_t tx_kind_i,
  input wire logic [7:0] tx_da_i,
  input wire logic [7:0] tx_tc_i,
  input wire logic [7:0] tx_ac_i,
  output logic tx_ready_o,
  // frames to the device
  input wire logic [7:0] own_i,
  output logic rx_valid_o,
  output tsa_pkg::tsa_kind_t rx_kind_o,
  output logic [7:0] rx_da_o,
  output logic [7:0] rx_sa_o,
  output logic [7:0] rx_tc_o,
  output logic [7:0] rx_ac_o
);
  bit present [256];
  int stall = 0;
  int wait_cnt = 0;
  int taken = 0;
  logic [7:0] ack_ac = 8'h00;
  tsa_kind_t last_kind;
  logic [7:0] last_da;
  logic [7:0] last_ctl;
  logic [7:0] last_ac;
  logic [7:0] tok_q [$];
  event took;

  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_kind_o = KIND_DATA;
    rx_da_o = 8'h00;
    rx_sa_o = 8'h00;
    rx_tc_o = 8'h00;
    rx_ac_o = 8'h00;
  end

  // idle fields show the inverse, so a stale frame never looks fresh
  task automatic send(input tsa_kind_t k, input logic [7:0] da, input logic [7:0] sa,
                      input logic [7:0] tc, input logic [7:0] ac);
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b1;
    rx_kind_o <= k;
    rx_da_o <= da;
    rx_sa_o <= sa;
    rx_tc_o <= tc;
    rx_ac_o <= ac;
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_kind_o <= tsa_kind_t'(~k);
    rx_da_o <= ~da;
    rx_sa_o <= ~sa;
    rx_tc_o <= ~tc;
    rx_ac_o <= ~ac;
  endtask : send

  always @(posedge sys_clk_i) begin
    tx_ready_o <= 1'b0;
    if (tx_valid_i && !tx_ready_o) begin
      if (wait_cnt < stall) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        tx_ready_o <= 1'b1;
        last_kind <= tx_kind_i;
        last_da <= tx_da_i;
        last_ctl <= tx_tc_i;
        last_ac <= tx_ac_i;
        taken <= taken + 1;
        if (tx_kind_i == KIND_TOKEN) tok_q.push_back(tx_da_i);
        -> took;
      end
    end
  end

  initial begin : answer_proc
    tsa_kind_t k;
    logic [7:0] da;
    logic [7:0] tc;
    forever begin
      @took;
      k = tx_kind_i;
      da = tx_da_i;
      tc = tx_tc_i;
      repeat (4) @(posedge sys_clk_i);
      if (k == KIND_DATA && tc == TC_ACK_REQ && present[da]) begin
        send(KIND_ACK, own_i, da, TC_NONE, ack_ac);
      end else if (k == KIND_TOKEN && present[da]) begin
        send(KIND_DATA, own_i, da, TC_NONE, 8'h00);
      end
    end
  end
endmodule : tsa_net_model

// *** testbench/tsa_station_add_tb.sv ***
// self-checking bench for the station-addition block
`timescale 1ns/1ps
module tsa_station_add_tb;
  import tsa_pkg::*;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic rx_valid_i;
  tsa_kind_t rx_kind_i;
  logic [7:0] rx_da_i;
  logic [7:0] rx_sa_i;
  logic [7:0] rx_tc_i;
  logic [7:0] rx_ac_i;
  logic tok_pass_i = 1'b0;
  logic tx_valid_o;
  tsa_kind_t tx_kind_o;
  logic [7:0] tx_da_o;
  logic [7:0] tx_tc_o;
  logic [7:0] tx_ac_o;
  logic tx_ready_i;
  logic fs_wr_o;
  logic [9:0] fs_code_o;
  logic na_changed_o;
  logic scan_mode_o;
  logic [7:0] own_q = 8'h0A;
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] rst_a [8] = '{REG_CTRL, REG_OWN, REG_NEXT, REG_STATUS, REG_ACKWAIT,
                            REG_POLL, REG_RESULT, 8'h1C};
  logic [7:0] rst_v [8] = '{8'h00, OWN_RST, NEXT_RST, 8'h00, ACKWAIT_RST, 8'h01, 8'h00, 8'h00};
  logic [7:0] scan_da [3] = '{8'h32, 8'hFF, 8'h0A};

  tsa_station_add dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid_i),
    .rx_kind_i(rx_kind_i), .rx_da_i(rx_da_i), .rx_sa_i(rx_sa_i), .rx_tc_i(rx_tc_i),
    .rx_ac_i(rx_ac_i), .tok_pass_i(tok_pass_i), .tx_valid_o(tx_valid_o),
    .tx_kind_o(tx_kind_o), .tx_da_o(tx_da_o), .tx_tc_o(tx_tc_o), .tx_ac_o(tx_ac_o),
    .tx_ready_i(tx_ready_i), .fs_wr_o(fs_wr_o), .fs_code_o(fs_code_o),
    .na_changed_o(na_changed_o), .scan_mode_o(scan_mode_o));

  tsa_net_model model_u (.sys_clk_i(sys_clk_i), .tx_valid_i(tx_valid_o),
    .tx_kind_i(tx_kind_o), .tx_da_i(tx_da_o), .tx_tc_i(tx_tc_o), .tx_ac_i(tx_ac_o),
    .tx_ready_o(tx_ready_i), .own_i(own_q), .rx_valid_o(rx_valid_i), .rx_kind_o(rx_kind_i),
    .rx_da_o(rx_da_i), .rx_sa_o(rx_sa_i), .rx_tc_o(rx_tc_i), .rx_ac_o(rx_ac_i));

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= {24'h00_0000, d};
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(name, exp, reg_rdata_o);
  endtask : rd_chk

  task automatic wait_frames(input int n);
    int t0;
    int i;
    t0 = model_u.taken;
    for (i = 0; i < 3000 && model_u.taken < t0 + n; i++) @(posedge sys_clk_i);
    check("frames taken", t0 + n, model_u.taken);
  endtask : wait_frames

  task automatic wait_fs();
    int i;
    for (i = 0; i < 1000 && fs_wr_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    check("status write", 1, fs_wr_o);
  endtask : wait_fs

  task automatic pass_token();
    @(posedge sys_clk_i);
    tok_pass_i <= 1'b1;
    @(posedge sys_clk_i);
    tok_pass_i <= 1'b0;
  endtask : pass_token

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // a full run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    end_of_test();
  end

  initial begin : main
    int i;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (i = 0; i < 8; i++) rd_chk("reset value", rst_a[i], rst_v[i]);
    reg_wr(REG_OWN, 8'h00);
    rd_chk("own zero refused", REG_OWN, 32'h0000_0001);
    reg_wr(REG_OWN, 8'hFF);
    rd_chk("own global refused", REG_OWN, 32'h0000_0001);
    reg_wr(REG_OWN, 8'h0A);
    reg_wr(REG_ACKWAIT, 8'h01);
    // poll a present station while the far side is slow to accept
    model_u.present[12] = 1'b1;
    model_u.ack_ac = 8'h05;
    model_u.stall = 3;
    reg_wr(REG_POLL, 8'h0C);
    wait_frames(1);
    check("poll kind", KIND_DATA, model_u.last_kind);
    check("poll dest", 8'h0C, model_u.last_da);
    check("poll token ctl", TC_ACK_REQ, model_u.last_ctl);
    wait_fs();
    check("poll acked", {OUT_ACKED, 8'h05}, fs_code_o);
    // silent address: abandoned after the wait; a 40-cycle idle gap spaces the polls
    repeat (40) @(posedge sys_clk_i);
    reg_wr(REG_POLL, 8'h0D);
    wait_fs();
    check("poll timeout", {OUT_TIMEOUT, 8'h00}, fs_code_o);
    rd_chk("result", REG_RESULT, {22'h00_0000, OUT_TIMEOUT, 8'h00});
    model_u.stall = 0;
    model_u.present[12] = 1'b0;
    // every control bit combination reaches the reply
    for (i = 0; i < 8; i++) begin
      reg_wr(REG_CTRL, 8'(i));
      model_u.send(KIND_DATA, 8'h0A, 8'h1E, TC_ACK_REQ, 8'h00);
      wait_frames(1);
      check("ack kind", KIND_ACK, model_u.last_kind);
      check("ack dest", 8'h1E, model_u.last_da);
      check("ack token ctl", TC_NONE, model_u.last_ctl);
      check("ack bits", 8'(i), model_u.last_ac);
    end
    // scan: foreign destination ignored, global and directed honoured
    for (i = 0; i < 3; i++) begin
      reg_wr(REG_NEXT, 8'h28);
      reg_wr(REG_STATUS, 8'h01);
      model_u.send(KIND_SCAN, scan_da[i], 8'h04, TC_NONE, 8'h00);
      rd_chk("scan next", REG_NEXT, (i == 0) ? 32'h0000_0028 : 32'h0000_000B);
      check("next changed", i != 0, na_changed_o);
      check("scan mode", i != 0, scan_mode_o);
    end
    // search steps 11, 12, 13 once each until 14 answers
    model_u.present[14] = 1'b1;
    model_u.tok_q.delete();
    pass_token();
    wait_frames(4);
    repeat (20) @(posedge sys_clk_i);
    check("token order", 32'h0B0C_0D0E,
          {model_u.tok_q[0], model_u.tok_q[1], model_u.tok_q[2], model_u.tok_q[3]});
    check("token count", 4, model_u.tok_q.size());
    check("token ctl", 8'h0E, model_u.last_ctl);
    rd_chk("next found", REG_NEXT, 32'h0000_000E);
    check("scan ended", 0, scan_mode_o);
    // top of the station range wraps to 1
    reg_wr(REG_OWN, 8'hFE);
    own_q = 8'hFE;
    model_u.send(KIND_SCAN, 8'hFE, 8'h04, TC_NONE, 8'h00);
    rd_chk("scan wrap", REG_NEXT, 32'h0000_0001);
    reg_wr(REG_OWN, 8'hFD);
    own_q = 8'hFD;
    model_u.send(KIND_SCAN, 8'hFD, 8'h04, TC_NONE, 8'h00);
    rd_chk("scan top", REG_NEXT, 32'h0000_00FE);
    model_u.present[14] = 1'b0;
    model_u.present[1] = 1'b1;
    model_u.tok_q.delete();
    pass_token();
    wait_frames(2);
    repeat (20) @(posedge sys_clk_i);
    check("wrap tokens", 16'hFE01, {model_u.tok_q[0], model_u.tok_q[1]});
    rd_chk("wrap found", REG_NEXT, 32'h0000_0001);
    // outside scan a silent station gets a second try before the step
    reg_wr(REG_NEXT, 8'h05);
    model_u.present[6] = 1'b1;
    model_u.tok_q.delete();
    pass_token();
    wait_frames(3);
    repeat (20) @(posedge sys_clk_i);
    check("retry tokens", 24'h05_0506,
          {model_u.tok_q[0], model_u.tok_q[1], model_u.tok_q[2]});
    rd_chk("retry found", REG_NEXT, 32'h0000_0006);
    end_of_test();
  end
endmodule : tsa_station_add_tb
